// file: tb/dmm_host.sv
// dmm_host: host side of the register port, behavioural.
// assumes wr and rd are called from one process at a time.
`default_nettype none
module dmm_host (
    input  wire logic       mclk,      // clock
    output logic            reg_wr,    // write strobe
    output logic            reg_rd,    // read strobe
    output logic      [7:0] reg_addr,  // offset
    output logic      [7:0] reg_wdata, // write data
    input  wire logic [7:0] reg_rdata, // read data
    input  wire logic       reg_rvalid // read valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a; // stale values must not look valid
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge mclk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rvalid ? reg_rdata : 8'hxx;
    endtask : rd
endmodule : dmm_host
`default_nettype wire

// file: tb/dmm_regs_monitor.sv
// dmm_regs_monitor: port-level assertions for the register bank.
// assumes one clock mclk and a synchronous active-high reset.
`default_nettype none
module dmm_regs_monitor
    import dmm_pkg::*;
#(
    parameter int CONV_CYCLES = 4
) (
    input wire logic       mclk,                         // clock
    input wire logic       reset,                        // sync reset
    input wire logic       reg_wr,                       // write strobe
    input wire logic       reg_rd,                       // read strobe
    input wire logic [7:0] reg_addr,                     // offset
    input wire logic [7:0] reg_wdata,                    // write data
    input wire logic       reg_rvalid,                   // read valid
    input wire logic       otp_load,                     // default load
    input wire logic       external_monitor_one,         // level
    input wire logic       external_monitor_two,         // level
    input wire logic       analog_supply_rail,           // level
    input wire logic       monitor_one_powergood_irq,    // pulse
    input wire logic       monitor_two_powergood_irq,    // pulse
    input wire logic       analog_supply_powergood_irq,  // pulse
    input wire logic       monitor_one_powergood_flag,   // status
    input wire logic       monitor_two_powergood_flag,   // status
    input wire logic       analog_supply_powergood_flag, // status
    input wire logic       meas_busy,                    // measuring
    input wire logic       meas_second,                  // converter
    input wire logic [1:0] step_up_current_limit_code    // boost limit
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    property p_flags;
        !$past(reset) |-> {monitor_one_powergood_flag,
            monitor_two_powergood_flag, analog_supply_powergood_flag}
            == $past({external_monitor_one, external_monitor_two,
            analog_supply_rail});
    endproperty
    a_flags: assert property (p_flags) else $error("flag lag");
    property p_irq_two;
        monitor_two_powergood_irq |-> $changed(monitor_two_powergood_flag)
            || $past(monitor_two_powergood_flag)
            != $past(monitor_two_powergood_flag, 2);
    endproperty
    a_irq_two: assert property (p_irq_two) else $error("irq2");
    property p_irq_one;
        monitor_one_powergood_irq |-> $changed(monitor_one_powergood_flag)
            || $past(monitor_one_powergood_flag)
            != $past(monitor_one_powergood_flag, 2);
    endproperty
    a_irq_one: assert property (p_irq_one) else $error("irq1");
    property p_irq_ana;
        analog_supply_powergood_irq
            |-> $changed(analog_supply_powergood_flag)
            || $past(analog_supply_powergood_flag)
            != $past(analog_supply_powergood_flag, 2);
    endproperty
    a_irq_ana: assert property (p_irq_ana) else $error("irqa");
    property p_busy;
        reg_wr && reg_addr == DMM_SEL_ADDR && !otp_load |=> meas_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("no start");
    property p_sel;
        reg_wr && reg_addr == DMM_SEL_ADDR && !otp_load
            |=> ##1 meas_second == $past(reg_wdata[0], 2);
    endproperty
    a_sel: assert property (p_sel) else $error("sel");
    property p_ilim;
        reg_wr && reg_addr == DMM_ILIM_ADDR && !otp_load
            |=> step_up_current_limit_code == $past(reg_wdata[1:0]);
    endproperty
    a_ilim: assert property (p_ilim) else $error("ilim");
    property p_rvalid;
        !$past(reset) |-> reg_rvalid == $past(reg_rd);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("rvalid");
    property p_hold;
        $fell(meas_busy) |-> $past(meas_busy, CONV_CYCLES);
    endproperty
    a_hold: assert property (p_hold) else $error("short meas");
endmodule : dmm_regs_monitor
bind dmm_regs dmm_regs_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (
    .mclk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid,
    .otp_load, .external_monitor_one, .external_monitor_two,
    .analog_supply_rail, .monitor_one_powergood_irq,
    .monitor_two_powergood_irq, .analog_supply_powergood_irq,
    .monitor_one_powergood_flag, .monitor_two_powergood_flag,
    .analog_supply_powergood_flag, .meas_busy, .meas_second,
    .step_up_current_limit_code
);
`default_nettype wire

// file: tb/testbench.sv
// testbench: directed scenarios for the register bank.
// assumes dmm_host drives the register port and a short conversion.
`default_nettype none
module testbench
    import dmm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 4;
    logic       mclk, reset, reg_wr, reg_rd, reg_rvalid, otp_load, up;
    logic       i1, i2, ia, f1, f2, fa, mon1, mon2, ana, busy, sec;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] otp_mask;
    logic [1:0] dn, lim, ecc, ilim;
    logic [8:0] s1, s2;
    int         mismatches, checks, n[3];
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;
    always @(negedge mclk) n = '{n[0] + ia, n[1] + i1, n[2] + i2};
    dmm_host u_host (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid);
    dmm_regs #(.CONV_CYCLES(CONV)) u_dmm_regs (.mclk, .reset, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .otp_load,
        .otp_mask, .otp_up_freq(up), .otp_down_freq(dn), .otp_up_ilim(lim),
        .otp_ecc(ecc), .external_monitor_one(mon1),
        .external_monitor_two(mon2), .analog_supply_rail(ana),
        .sense_first(s1), .sense_second(s2),
        .monitor_one_powergood_irq(i1), .monitor_two_powergood_irq(i2),
        .analog_supply_powergood_irq(ia), .monitor_one_powergood_flag(f1),
        .monitor_two_powergood_flag(f2), .analog_supply_powergood_flag(fa),
        .meas_busy(busy), .meas_second(sec),
        .step_up_current_limit_code(ilim));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic t_otp;
        logic [7:0] d;
        for (int i = 0; i < 2; i++) begin
            otp_mask = i ? 6'h15 : 6'h2a;
            up       = i[0];
            dn       = i ? 2'h3 : 2'h1;
            lim      = i ? 2'h1 : 2'h2;
            ecc      = i ? 2'h2 : 2'h1;
            otp_load = 1'b1;
            u_host.wr(DMM_ILIM_ADDR, 8'h03);
            otp_load = 1'b0;
            u_host.wr(DMM_FREQ_ADDR, 8'hff);
            u_host.rd(DMM_DIAGNOSTIC_INTERRUPT_MASKS_ADDR, d);
            chk("mask", {2'b00, otp_mask}, d);
            u_host.rd(DMM_FREQ_ADDR, d);
            chk("freq", {5'h00, up, dn}, d);
            u_host.rd(DMM_ILIM_ADDR, d);
            chk("ilim", {6'h00, lim}, d);
            u_host.rd(DMM_ECC_ADDR, d);
            chk("ecc", {6'h00, ecc}, d);
        end
    endtask : t_otp
    task automatic t_ilim;
        logic [7:0] d;
        for (int c = 0; c < 4; c++) begin
            u_host.wr(DMM_ILIM_ADDR, 8'hfc | 8'(c));
            u_host.rd(DMM_ILIM_ADDR, d);
            chk("ilim", 8'(c), d);
            chk("ilim_port", 8'(c), {6'h00, ilim});
        end
        u_host.rd(8'h34, d);
        chk("unmapped", 8'h00, d);
    endtask : t_ilim
    task automatic t_mask;
        logic [5:0] m;
        for (int b = 0; b < 7; b++) begin
            m = (b < 6) ? 6'(1 << b) : 6'h00;
            u_host.wr(DMM_DIAGNOSTIC_INTERRUPT_MASKS_ADDR, {2'b11, m});
            n = '{0, 0, 0};
            {mon1, mon2, ana} = 3'b111;
            repeat (4) @(posedge mclk);
            #1 chk("flags_up", 8'h07, {5'h00, f1, f2, fa});
            {mon1, mon2, ana} = 3'b000;
            repeat (4) @(posedge mclk);
            #1 chk("flags_dn", 8'h00, {5'h00, f1, f2, fa});
            for (int k = 0; k < 3; k++)
                chk("irqs", 8'(2 - m[2*k] - m[2*k+1]), 8'(n[k]));
        end
    endtask : t_mask
    task automatic t_meas;
        logic [7:0] hi, lo;
        logic [8:0] v;
        int         code;
        s1 = 9'h1ff;
        s2 = 9'h0a5;
        for (int c = 0; c < 6; c++) begin
            code = (c < 4) ? c : 3;
            u_host.wr(DMM_SEL_ADDR, 8'(code));
            for (int t = 0; busy && t < 50; t++) begin
                @(posedge mclk);
                #1;
            end
            v = code[0] ? s2 : s1;
            if (v > DMM_RES_MAX) v = DMM_RES_MAX; // full scale clip
            u_host.rd(DMM_RES_HIGH_ADDR, hi);
            u_host.rd(DMM_RES_LOW_ADDR, lo);
            chk("sec", {7'h00, code[0]}, {7'h00, sec});
            chk("res_hi", {7'h00, v[8]}, hi);
            chk("res_lo", v[7:0], lo);
            s1 = s1 >> 1;
            s2 = s2 + 9'h011;
            u_host.rd(DMM_RES_LOW_ADDR, lo);
            chk("res_hold", v[7:0], lo);
        end
    endtask : t_meas
    initial begin
        {reset, otp_load, up, mon1, mon2, ana} = 6'b100000;
        {otp_mask, dn, lim, ecc, s1, s2} = '0;
        mismatches = 0;
        checks = 0;
        repeat (8) @(posedge mclk);
        #1 reset = 1'b0;
        t_otp();
        t_ilim();
        t_mask();
        t_meas();
        summarize();
    end
    initial begin
        #100us;
        mismatches++;
        summarize();
    end
endmodule : testbench
`default_nettype wire

// file: verilog/dmm_pkg.sv
// dmm_pkg: register map, field positions and timing for the diagnostic
// mask and load-current measurement register bank.
// assumes an 8-bit register port with 8-bit offsets, one clock.
`default_nettype none
package dmm_pkg;
    localparam logic [7:0] DMM_DIAGNOSTIC_INTERRUPT_MASKS_ADDR  = 8'h2d;
    localparam logic [7:0] DMM_SEL_ADDR        = 8'h2e;
    localparam logic [7:0] DMM_RES_HIGH_ADDR   = 8'h2f;
    localparam logic [7:0] DMM_RES_LOW_ADDR    = 8'h30;
    localparam logic [7:0] DMM_FREQ_ADDR       = 8'h31;
    localparam logic [7:0] DMM_ILIM_ADDR       = 8'h32;
    localparam logic [7:0] DMM_ECC_ADDR        = 8'h33;

    // diagnostic mask bit positions
    localparam int DMM_M2_INVALID_BIT = 5;
    localparam int DMM_M2_VALID_BIT   = 4;
    localparam int DMM_M1_INVALID_BIT = 3;
    localparam int DMM_M1_VALID_BIT   = 2;
    localparam int DMM_AN_INVALID_BIT = 1;
    localparam int DMM_AN_VALID_BIT   = 0;
    localparam logic [7:0] DMM_MASK_WMASK = 8'h3f;

    localparam logic [7:0] DMM_SEL_RESET  = 8'h00;
    localparam logic [8:0] DMM_RES_RESET  = 9'h000;
    localparam int DMM_FREQ_UP_BIT        = 2;

    // one step of the result is 20 mA, full scale 10 A
    localparam int DMM_LSB_MA             = 20;
    localparam int DMM_FULL_SCALE_MA      = 10000;
    localparam logic [8:0] DMM_RES_MAX    = 9'(DMM_FULL_SCALE_MA / DMM_LSB_MA);

    // measurement conversion time
    localparam int DMM_CONV_TIME_NS       = 1000;
    localparam int DMM_CLK_PERIOD_NS      = 10;
    localparam int DMM_CONV_CYCLES        =
        (DMM_CONV_TIME_NS + DMM_CLK_PERIOD_NS - 1) / DMM_CLK_PERIOD_NS;
endpackage : dmm_pkg
`default_nettype wire

// file: verilog/dmm_regs.sv
// dmm_regs: diagnostic interrupt masks, load-current measurement trigger
// and result, switching-frequency report and boost current limit.
// assumes a synchronous single-cycle register port behind the serial
// interface, configuration memory defaults valid while load is high, and
// a current-sense sample from the analog front end.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// [R1] mask bit 5 set blocks the monitor two invalid interrupt, clear passes it.
// [R2] mask bit 4 set blocks the monitor two valid interrupt, clear passes it.
// [R3] mask bit 3 set blocks the monitor one invalid interrupt, clear passes it.
// [R4] mask bit 2 set blocks the monitor one valid interrupt, clear passes it.
// [R5] mask bit 1 set blocks the analog rail invalid interrupt, clear passes it.
// [R6] mask bit 0 set blocks the analog rail valid interrupt, clear passes it.
// [R7] masks gate only interrupts; power-good flags always follow the input.
// [R8] masks, frequency and current-limit defaults come from config memory.
// [R9] select codes 0 and 2 measure the first converter, 1 and 3 the second.
// [R10] every write to the select register starts a new measurement.
// [R11] the 9-bit result has its msb in bit 0 of high, low byte in low.
// [R12] one result step is 20 mA, range up to 10 A.
// [R13] frequency bit 2 reports boost frequency, 0 = 2 MHz, 1 = 4 MHz.
// [R14] frequency bits 1-0 report step-down frequency 2, 3, 4, 4 MHz.
// [R15] writable 2-bit boost limit field selects 1.0, 1.4, 1.9, 2.8 A.
// [R16] result holds the last completed value until the next one completes.
module dmm_regs
    import dmm_pkg::*;
#(
    parameter int CONV_CYCLES = DMM_CONV_CYCLES
) (
    input  wire logic       mclk,                 // 100 MHz clock
    input  wire logic       reset,                // sync reset, active high
    input  wire logic       reg_wr,               // register write strobe
    input  wire logic       reg_rd,               // register read strobe
    input  wire logic [7:0] reg_addr,             // register offset
    input  wire logic [7:0] reg_wdata,            // write data
    output logic      [7:0] reg_rdata,            // read data
    output logic            reg_rvalid,           // read data valid pulse
    input  wire logic       otp_load,             // load defaults from memory
    input  wire logic [5:0] otp_mask,             // mask defaults
    input  wire logic       otp_up_freq,          // boost frequency code
    input  wire logic [1:0] otp_down_freq,        // step-down frequency code
    input  wire logic [1:0] otp_up_ilim,          // boost limit default
    input  wire logic [1:0] otp_ecc,              // correction status
    input  wire logic       external_monitor_one, // monitor one good level
    input  wire logic       external_monitor_two, // monitor two good level
    input  wire logic       analog_supply_rail,   // analog rail good level
    input  wire logic [8:0] sense_first,          // first converter current
    input  wire logic [8:0] sense_second,         // second converter current
    output logic            monitor_one_powergood_irq,   // event pulse
    output logic            monitor_two_powergood_irq,   // event pulse
    output logic            analog_supply_powergood_irq, // event pulse
    output logic            monitor_one_powergood_flag,  // status level
    output logic            monitor_two_powergood_flag,  // status level
    output logic            analog_supply_powergood_flag,// status level
    output logic            meas_busy,            // measurement running
    output logic            meas_second,          // second converter chosen
    output logic [1:0]      step_up_current_limit_code   // boost limit
);

    typedef enum logic [0:0] {DMM_IDLE, DMM_MEAS} dmm_state_t;

    function automatic logic [8:0] dmm_clip(input logic [8:0] v);
        dmm_clip = (v > DMM_RES_MAX) ? DMM_RES_MAX : v; // R12
    endfunction : dmm_clip

    logic [5:0]  mask_reg;
    logic [1:0]  sel_reg;
    logic [8:0]  result_reg;
    logic        step_up_frequency_code;
    logic [1:0]  step_down_frequency_code;
    logic [1:0]  ecc_reg;
    logic [2:0]  good_reg;
    dmm_state_t  state_reg;
    logic [15:0] cnt_reg;
    logic [8:0]  sample;
    logic [2:0]  good_now;
    logic [2:0]  rise;
    logic [2:0]  fall;

    ////////////////////////////////////////////////////////////////////////////
    // masks and boost limit, defaults from configuration memory

    always_ff @(posedge mclk) begin
        if (reset) begin
            mask_reg                   <= 6'h00;
            step_up_current_limit_code <= 2'h0;
        end else if (otp_load) begin
            mask_reg                   <= otp_mask;      // R8
            step_up_current_limit_code <= otp_up_ilim;   // R8
        end else if (reg_wr) begin
            if (reg_addr == DMM_DIAGNOSTIC_INTERRUPT_MASKS_ADDR) begin
                mask_reg <= reg_wdata[5:0];
            end else if (reg_addr == DMM_ILIM_ADDR) begin
                step_up_current_limit_code <= reg_wdata[1:0]; // R15
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            step_up_frequency_code   <= 1'b0;
            step_down_frequency_code <= 2'h0;
            ecc_reg                  <= 2'h0;
        end else if (otp_load) begin
            step_up_frequency_code   <= otp_up_freq;   // R8 R13
            step_down_frequency_code <= otp_down_freq; // R8 R14
            ecc_reg                  <= otp_ecc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-good tracking and masked interrupt events

    assign good_now = {external_monitor_two, external_monitor_one,
                       analog_supply_rail};
    assign rise = good_now & ~good_reg;
    assign fall = ~good_now & good_reg;

    always_ff @(posedge mclk) begin
        if (reset) begin
            good_reg                     <= 3'h0;
            monitor_one_powergood_flag   <= 1'b0;
            monitor_two_powergood_flag   <= 1'b0;
            analog_supply_powergood_flag <= 1'b0;
        end else begin
            good_reg                     <= good_now;
            monitor_two_powergood_flag   <= good_now[2]; // R7
            monitor_one_powergood_flag   <= good_now[1]; // R7
            analog_supply_powergood_flag <= good_now[0]; // R7
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            monitor_one_powergood_irq   <= 1'b0;
            monitor_two_powergood_irq   <= 1'b0;
            analog_supply_powergood_irq <= 1'b0;
        end else begin
            monitor_two_powergood_irq <=
                (fall[2] & ~mask_reg[DMM_M2_INVALID_BIT])   // R1
              | (rise[2] & ~mask_reg[DMM_M2_VALID_BIT]);    // R2
            monitor_one_powergood_irq <=
                (fall[1] & ~mask_reg[DMM_M1_INVALID_BIT])   // R3
              | (rise[1] & ~mask_reg[DMM_M1_VALID_BIT]);    // R4
            analog_supply_powergood_irq <=
                (fall[0] & ~mask_reg[DMM_AN_INVALID_BIT])   // R5
              | (rise[0] & ~mask_reg[DMM_AN_VALID_BIT]);    // R6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // load-current measurement

    assign sample = sel_reg[0] ? sense_second : sense_first; // R9

    always_ff @(posedge mclk) begin
        if (reset) begin
            sel_reg <= DMM_SEL_RESET[1:0];
        end else if (reg_wr && reg_addr == DMM_SEL_ADDR) begin
            sel_reg <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg  <= DMM_IDLE;
            cnt_reg    <= 16'h0000;
            result_reg <= DMM_RES_RESET;
            meas_busy  <= 1'b0;
        end else if (reg_wr && reg_addr == DMM_SEL_ADDR) begin
            // a write restarts even while a measurement is running
            state_reg <= DMM_MEAS;                   // R10
            cnt_reg   <= 16'(CONV_CYCLES - 1);
            meas_busy <= 1'b1;
        end else begin
            case (state_reg)
                DMM_IDLE: begin
                    meas_busy <= 1'b0;
                end
                DMM_MEAS: begin
                    if (cnt_reg == 16'h0000) begin
                        result_reg <= dmm_clip(sample);  // R16
                        state_reg  <= DMM_IDLE;
                        meas_busy  <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 16'h0001;
                    end
                end
                default: state_reg <= DMM_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            meas_second <= 1'b0;
        end else begin
            meas_second <= sel_reg[0]; // R9
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, unmapped offsets read zero

    always_ff @(posedge mclk) begin
        if (reset) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (!reg_rd) begin
                reg_rdata <= 8'h00;
            end else if (reg_addr == DMM_DIAGNOSTIC_INTERRUPT_MASKS_ADDR) begin
                reg_rdata <= {2'h0, mask_reg} & DMM_MASK_WMASK;
            end else if (reg_addr == DMM_SEL_ADDR) begin
                reg_rdata <= {6'h00, sel_reg};
            end else if (reg_addr == DMM_RES_HIGH_ADDR) begin
                reg_rdata <= {7'h00, result_reg[8]};  // R11
            end else if (reg_addr == DMM_RES_LOW_ADDR) begin
                reg_rdata <= result_reg[7:0];         // R11
            end else if (reg_addr == DMM_FREQ_ADDR) begin
                reg_rdata <= {5'h00, step_up_frequency_code,
                              step_down_frequency_code}; // R13 R14
            end else if (reg_addr == DMM_ILIM_ADDR) begin
                reg_rdata <= {6'h00, step_up_current_limit_code}; // R15
            end else if (reg_addr == DMM_ECC_ADDR) begin
                reg_rdata <= {6'h00, ecc_reg};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

endmodule : dmm_regs
`default_nettype wire
